// [design/perf_unit_pkg.sv]
// Shared constants for the performance event counter unit.
// Assumes a single core clock and a simple indexed register port.
package perf_unit_pkg;

  // ==========================================================
  // Widths
  localparam int CTR_W = 48;
  localparam int REG_W = 64;
  localparam int CTL_W = 32;
  localparam int STATUS_W = 32;
  localparam int ADDR_W = 4;
  localparam int FIELD8_W = 8;

  // ==========================================================
  // Register indices
  localparam logic [ADDR_W-1:0] IDX_UNIT_CTL = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_UNIT_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_CTL_BASE = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_CTR_BASE = 4'h8;

  // ==========================================================
  // Unit control bits
  localparam int UC_RST_CTRS = 9;
  localparam int UC_RST_CTL = 8;
  localparam int UC_FREEZE = 0;

  // ==========================================================
  // Counter control fields
  localparam int CC_THRESH_LO = 24;
  localparam int CC_INVERT = 23;
  localparam int CC_WRAP_MSG = 20;
  localparam int CC_EDGE = 18;
  localparam int CC_CLEAR = 17;
  localparam int CC_SUBEV_LO = 8;
  localparam int CC_EVENT_LO = 0;
  localparam logic [CTL_W-1:0] CC_RW_MASK = 32'hFF94FFFF;

  // ==========================================================
  // Reset values
  localparam logic [CTL_W-1:0] CTL_RESET = 32'h0;
  localparam logic [CTR_W-1:0] CTR_RESET = 48'h0;

endpackage

// [design/shaper_if.sv]
// Interface between the unit and one event shaping slice.
// Assumes both ends run on the unit clock.
`timescale 1ns/1ps
interface shaper_if #(
  parameter int INCR_W = 8
);
  logic [perf_unit_pkg::FIELD8_W-1:0] thresh;
  logic invert;
  logic edge_det;
  logic count_en;
  logic [INCR_W-1:0] incr;
  logic [INCR_W-1:0] step;

  modport owner(output thresh, invert, edge_det, count_en, incr,
    input step);
  modport shaper(input thresh, invert, edge_det, count_en, incr,
    output step);
endinterface

// [design/perf_event_shaper.sv]
// Turns one event's raw increment into the counter step.
// Assumes the increment comes from logic on the same clock.
`timescale 1ns/1ps
module perf_event_shaper (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  shaper_if.shaper port
);

  typedef struct packed {
    logic prev_q;
  } shaper_state_t;

  shaper_state_t st_reg;
  shaper_state_t st_next;
  logic qual;
  logic thr_on;

  // ==========================================================
  // Threshold, invert and edge shaping
  always_comb begin
    thr_on = port.thresh != '0;
    qual = (port.incr >= $bits(port.incr)'(port.thresh)) ^
      port.invert; // see R7 see R8
    st_next.prev_q = qual;
    port.step = '0;
    if (!port.count_en) begin
      port.step = '0;
    end else if (!thr_on) begin
      port.step = port.incr;
    end else if (port.edge_det) begin
      port.step = $bits(port.step)'(qual && !st_reg.prev_q); // see R9 see R10
    end else begin
      port.step = $bits(port.step)'(qual); // see R10
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  sequence level_mode;
    port.count_en && thr_on && !port.edge_det;
  endsequence

  level_cmp_a: assert property ( // see R7 see R8
    level_mode |-> (port.step != '0) ==
      (port.invert ? (port.incr < $bits(port.incr)'(port.thresh))
                   : (port.incr >= $bits(port.incr)'(port.thresh))))
    else $error("threshold step mismatch");

  edge_once_a: assert property ( // see R9 see R10
    (port.count_en && thr_on && port.edge_det && qual) [*2]
      |-> port.step == '0)
    else $error("edge mode counted a held event");

endmodule // perf_event_shaper

// [design/wrap_status.sv]
// Sticky per-counter wrap flags, cleared by writing ones.
// Assumes set pulses and clear writes come on the unit clock.
`timescale 1ns/1ps
module wrap_status #(
  parameter int PAIR_COUNT = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [PAIR_COUNT-1:0] i_set,
  input wire logic i_clear_wr,
  input wire logic [PAIR_COUNT-1:0] i_clear_mask,
  output logic [PAIR_COUNT-1:0] o_wrap_flags
);

  typedef struct packed {
    logic [PAIR_COUNT-1:0] flags;
  } status_state_t;

  status_state_t st_reg;
  status_state_t st_next;

  // ==========================================================
  // Set wins over clear
  always_comb begin
    st_next = st_reg;
    if (i_clear_wr) begin
      st_next.flags = st_reg.flags & ~i_clear_mask; // see R5
    end
    st_next.flags = st_next.flags | i_set; // see R4
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_wrap_flags = st_reg.flags;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  flag_set_a: assert property ( // see R4
    (|i_set) |=> ((o_wrap_flags & $past(i_set)) == $past(i_set)))
    else $error("wrap flag not set");

  w1c_clear_a: assert property ( // see R5
    i_clear_wr && i_clear_mask[0] && !i_set[0] |=> !o_wrap_flags[0])
    else $error("wrap flag not cleared");

  zero_keep_a: assert property ( // see R5
    o_wrap_flags[0] && !(i_clear_wr && i_clear_mask[0])
      |=> o_wrap_flags[0])
    else $error("wrap flag lost");

endmodule // wrap_status

// [design/perf_event_counter_unit.sv]
// Performance event counter unit: unit control, wrap status and
// counter/control pairs. Assumes an indexed 64-bit register port and a
// global monitor hub that runs on the same clock.
//
// What this block does
// R1: Writing one to unit control bit 9 clears all data counters.
// R2: Writing one to unit control bit 8 clears all control registers.
// R3: Unit control bit 0 freezes every counter of the unit.
// R4: A counter wrap sets the status flag at that counter's index.
// R5: Status flags clear on written ones, ignore zeros, reset to zero.
// R6: One status flag per pair; status bits above them read zero.
// R7: Nonzero threshold counts cycles with increment at least threshold.
// R8: Invert bit 23 turns the test into increment below threshold.
// R9: Invert plus edge counts falling edges of the threshold test.
// R10: Edge bit 18 counts rising edges; otherwise every qualifying cycle.
// R11: Software uses a nonzero threshold with invert or edge.
// R12: Control bit 20 sends a wrap message to the global hub.
// R13: Writing one to control bit 17 clears the paired counter.
// R14: Software writes zero to control bits 22:21 and 16.
// R15: Bits 7:0 pick the event, 15:8 the subevents; reset zero.
// R16: Counters are 48 bits; carry out of bit 47 is a wrap.
// R17: After a wrap the counter keeps counting until frozen.
// R18: Software preloads two to the 48 minus N to stop after N.
// R19: Software stops counters and checks status before reading.
// R20: The hub records the wrap, broadcasts freeze, may interrupt.
// R21: No new wrap message until the unit flag was cleared.
// R22: Control registers read as 64 bits; upper half is zero.
// R23: An event code of zero leaves the counter disabled.
// R24: The global freeze stops all counters of the unit.
// R25: Counters hold while either freeze is on, resume when both drop.
`timescale 1ns/1ps
module perf_event_counter_unit #(
  parameter int PAIR_COUNT = 4,
  parameter int INCR_W = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [perf_unit_pkg::ADDR_W-1:0] i_reg_idx,
  input wire logic [perf_unit_pkg::REG_W-1:0] i_reg_wdata,
  output logic [perf_unit_pkg::REG_W-1:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_global_freeze,
  output logic [PAIR_COUNT-1:0] o_wrap_msg,
  output logic o_frozen,
  output logic [PAIR_COUNT*perf_unit_pkg::FIELD8_W-1:0] o_event_code,
  output logic [PAIR_COUNT*perf_unit_pkg::FIELD8_W-1:0] o_subevent_mask,
  input wire logic [PAIR_COUNT*INCR_W-1:0] i_event_incr
);

  typedef struct packed {
    logic [PAIR_COUNT-1:0][perf_unit_pkg::CTL_W-1:0] ctl;
    logic [PAIR_COUNT-1:0][perf_unit_pkg::CTR_W-1:0] ctr;
    logic frozen;
    logic [PAIR_COUNT-1:0] msg;
    logic [perf_unit_pkg::REG_W-1:0] rdata;
    logic rvalid;
  } unit_state_t;

  unit_state_t st_reg;
  unit_state_t st_next;
  logic [PAIR_COUNT-1:0][INCR_W-1:0] step_w;
  logic [PAIR_COUNT-1:0] ovf;
  logic [PAIR_COUNT-1:0] flags;
  logic [PAIR_COUNT-1:0] msg_en;
  logic uc_wr;
  logic st_clr;

  // ==========================================================
  // Index decode
  function automatic logic reg_hit(
    input logic [perf_unit_pkg::ADDR_W-1:0] idx,
    input logic [perf_unit_pkg::ADDR_W-1:0] base,
    input int unsigned n
  );
    return idx == base + n[perf_unit_pkg::ADDR_W-1:0];
  endfunction

  assign uc_wr = i_reg_wr && i_reg_idx == perf_unit_pkg::IDX_UNIT_CTL;
  assign st_clr = i_reg_wr && i_reg_idx == perf_unit_pkg::IDX_UNIT_STATUS;

  // ==========================================================
  // Event shaping slices
  shaper_if #(.INCR_W(INCR_W)) sif [PAIR_COUNT] ();

  for (genvar g = 0; g < PAIR_COUNT; g++) begin : g_pair
    assign sif[g].thresh = st_reg.ctl[g][perf_unit_pkg::CC_THRESH_LO +:
      perf_unit_pkg::FIELD8_W];
    assign sif[g].invert = st_reg.ctl[g][perf_unit_pkg::CC_INVERT];
    assign sif[g].edge_det = st_reg.ctl[g][perf_unit_pkg::CC_EDGE];
    assign sif[g].count_en = !st_reg.frozen && !i_global_freeze &&
      st_reg.ctl[g][perf_unit_pkg::CC_EVENT_LO +:
      perf_unit_pkg::FIELD8_W] != '0; // see R23 see R24 see R25
    assign sif[g].incr = i_event_incr[g*INCR_W +: INCR_W];
    assign step_w[g] = sif[g].step;
    assign msg_en[g] = st_reg.ctl[g][perf_unit_pkg::CC_WRAP_MSG];
    assign o_event_code[g*perf_unit_pkg::FIELD8_W +:
      perf_unit_pkg::FIELD8_W] = st_reg.ctl[g][perf_unit_pkg::CC_EVENT_LO
      +: perf_unit_pkg::FIELD8_W]; // see R15
    assign o_subevent_mask[g*perf_unit_pkg::FIELD8_W +:
      perf_unit_pkg::FIELD8_W] = st_reg.ctl[g][perf_unit_pkg::CC_SUBEV_LO
      +: perf_unit_pkg::FIELD8_W]; // see R15

    perf_event_shaper u_shaper (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .port(sif[g].shaper)
    );
  end

  // ==========================================================
  // Wrap flags
  wrap_status #(.PAIR_COUNT(PAIR_COUNT)) u_status (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_set(ovf),
    .i_clear_wr(st_clr),
    .i_clear_mask(i_reg_wdata[PAIR_COUNT-1:0]),
    .o_wrap_flags(flags)
  );

  // ==========================================================
  // Next state
  always_comb begin
    logic [perf_unit_pkg::CTR_W:0] sum;
    sum = '0;
    st_next = st_reg;
    ovf = '0;
    st_next.msg = '0;
    st_next.rvalid = i_reg_rd;
    if (uc_wr) begin
      st_next.frozen = i_reg_wdata[perf_unit_pkg::UC_FREEZE]; // see R3
    end
    for (int i = 0; i < PAIR_COUNT; i++) begin
      sum = {1'b0, st_reg.ctr[i]} +
        {{(perf_unit_pkg::CTR_W + 1 - INCR_W){1'b0}}, step_w[i]};
      ovf[i] = sum[perf_unit_pkg::CTR_W]; // see R16
      st_next.ctr[i] = sum[perf_unit_pkg::CTR_W-1:0]; // see R17
      if (i_reg_wr && reg_hit(i_reg_idx, perf_unit_pkg::IDX_CTL_BASE, i))
        begin
        st_next.ctl[i] = i_reg_wdata[perf_unit_pkg::CTL_W-1:0] &
          perf_unit_pkg::CC_RW_MASK; // see R15 see R22
        if (i_reg_wdata[perf_unit_pkg::CC_CLEAR]) begin
          st_next.ctr[i] = perf_unit_pkg::CTR_RESET; // see R13
          ovf[i] = 1'b0;
        end
      end
      if (i_reg_wr && reg_hit(i_reg_idx, perf_unit_pkg::IDX_CTR_BASE, i))
        begin
        st_next.ctr[i] = i_reg_wdata[perf_unit_pkg::CTR_W-1:0];
        ovf[i] = 1'b0;
      end
      if (uc_wr && i_reg_wdata[perf_unit_pkg::UC_RST_CTRS]) begin
        st_next.ctr[i] = perf_unit_pkg::CTR_RESET; // see R1
        ovf[i] = 1'b0;
      end
      if (uc_wr && i_reg_wdata[perf_unit_pkg::UC_RST_CTL]) begin
        st_next.ctl[i] = perf_unit_pkg::CTL_RESET; // see R2
      end
      st_next.msg[i] = ovf[i] && msg_en[i] && !flags[i]; // see R12 see R21
    end
    if (i_reg_rd) begin
      st_next.rdata = '0;
      if (i_reg_idx == perf_unit_pkg::IDX_UNIT_STATUS) begin
        st_next.rdata[PAIR_COUNT-1:0] = flags; // see R6
      end
      for (int i = 0; i < PAIR_COUNT; i++) begin
        if (reg_hit(i_reg_idx, perf_unit_pkg::IDX_CTL_BASE, i)) begin
          st_next.rdata[perf_unit_pkg::CTL_W-1:0] = st_reg.ctl[i]; // see R22
        end
        if (reg_hit(i_reg_idx, perf_unit_pkg::IDX_CTR_BASE, i)) begin
          st_next.rdata[perf_unit_pkg::CTR_W-1:0] = st_reg.ctr[i];
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign o_reg_rdata = st_reg.rdata;
  assign o_reg_rvalid = st_reg.rvalid;
  assign o_wrap_msg = st_reg.msg; // see R20
  assign o_frozen = st_reg.frozen;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  sequence ctr_reset_wr;
    uc_wr && i_reg_wdata[perf_unit_pkg::UC_RST_CTRS];
  endsequence

  sequence wrap_cause;
    ovf[0] && msg_en[0] && !flags[0];
  endsequence

  sequence quiet_bus;
    !i_reg_wr;
  endsequence

  sequence ctl0_write;
    i_reg_wr && i_reg_idx == perf_unit_pkg::IDX_CTL_BASE;
  endsequence

  sequence ctr0_read;
    i_reg_rd && i_reg_idx == perf_unit_pkg::IDX_CTR_BASE;
  endsequence

  rst_ctrs_a: assert property ( // see R1
    ctr_reset_wr |=> st_reg.ctr == '0)
    else $error("counters not cleared");

  rst_ctl_a: assert property ( // see R2
    uc_wr && i_reg_wdata[perf_unit_pkg::UC_RST_CTL] |=> st_reg.ctl == '0)
    else $error("controls not cleared");

  unit_freeze_a: assert property ( // see R3 see R25
    st_reg.frozen && !i_reg_wr |=> $stable(st_reg.ctr))
    else $error("counter moved while unit frozen");

  global_freeze_a: assert property ( // see R24
    i_global_freeze ##0 quiet_bus |=> $stable(st_reg.ctr))
    else $error("counter moved under global freeze");

  status_read_a: assert property ( // see R6
    i_reg_rd && i_reg_idx == perf_unit_pkg::IDX_UNIT_STATUS
      |=> o_reg_rvalid && o_reg_rdata[perf_unit_pkg::REG_W-1:PAIR_COUNT]
      == '0 && o_reg_rdata[PAIR_COUNT-1:0] == $past(flags))
    else $error("status read wrong");

  wrap_msg_a: assert property ( // see R12
    wrap_cause |=> o_wrap_msg[0] ##1 !o_wrap_msg[0])
    else $error("wrap message missing");

  msg_gate_a: assert property ( // see R21
    ((o_wrap_msg & $past(flags)) == '0))
    else $error("wrap message while flag set");

  ctl_clear_a: assert property ( // see R13
    i_reg_wr && i_reg_idx == perf_unit_pkg::IDX_CTL_BASE &&
      i_reg_wdata[perf_unit_pkg::CC_CLEAR] |=> st_reg.ctr[0] == '0)
    else $error("paired counter not cleared");

  event_off_a: assert property ( // see R23
    st_reg.ctl[0][perf_unit_pkg::FIELD8_W-1:0] == '0 ##0 quiet_bus
      |=> $stable(st_reg.ctr[0]))
    else $error("disabled counter moved");

  ctl_read_a: assert property ( // see R22 see R14
    i_reg_rd && i_reg_idx == perf_unit_pkg::IDX_CTL_BASE
      |=> o_reg_rdata[perf_unit_pkg::REG_W-1:perf_unit_pkg::CTL_W] == '0
      && (o_reg_rdata[perf_unit_pkg::CTL_W-1:0] &
      ~perf_unit_pkg::CC_RW_MASK) == '0)
    else $error("control read shows reserved bits");

  wrap_around_a: assert property ( // see R16 see R17
    ovf[0] ##0 quiet_bus |=> st_reg.ctr[0] < $past(st_reg.ctr[0]))
    else $error("counter did not wrap");

  freeze_bit_a: assert property ( // see R3
    uc_wr |=> o_frozen == $past(i_reg_wdata[perf_unit_pkg::UC_FREEZE]))
    else $error("freeze bit not taken");

  ctl_write_a: assert property ( // see R15
    ctl0_write |=> st_reg.ctl[0] ==
      ($past(i_reg_wdata[perf_unit_pkg::CTL_W-1:0]) &
      perf_unit_pkg::CC_RW_MASK))
    else $error("control write not kept");

  ctr_read_a: assert property ( // see R16
    ctr0_read |=> o_reg_rdata[perf_unit_pkg::REG_W-1:perf_unit_pkg::CTR_W]
      == '0 && o_reg_rdata[perf_unit_pkg::CTR_W-1:0] ==
      $past(st_reg.ctr[0]))
    else $error("counter read wrong");

  ctr_write_a: assert property ( // see R16
    i_reg_wr && i_reg_idx == perf_unit_pkg::IDX_CTR_BASE
      |=> st_reg.ctr[0] == $past(i_reg_wdata[perf_unit_pkg::CTR_W-1:0]))
    else $error("counter write not kept");

  counter_add_a: assert property ( // see R17
    quiet_bus |=> st_reg.ctr[0] == $past(st_reg.ctr[0]) + $past(step_w[0]))
    else $error("counter step wrong");

  msg_pulse_a: assert property ( // see R21
    o_wrap_msg[0] |=> !o_wrap_msg[0])
    else $error("wrap message held");

  unit_ctl_read_a: assert property ( // see R1
    i_reg_rd && i_reg_idx == perf_unit_pkg::IDX_UNIT_CTL
      |=> o_reg_rdata == '0)
    else $error("unit control read not zero");

  read_answer_a: assert property ( // see R22
    i_reg_rd |=> o_reg_rvalid)
    else $error("read answer missing");

  event_gate_a: assert property ( // see R23
    st_reg.ctl[0][perf_unit_pkg::FIELD8_W-1:0] == '0
      |-> step_w[0] == '0)
    else $error("disabled counter stepped");

  global_hold_a: assert property ( // see R24
    i_global_freeze |-> step_w == '0)
    else $error("step under global freeze");

  unit_hold_a: assert property ( // see R3 see R25
    st_reg.frozen |-> step_w == '0)
    else $error("step while unit frozen");

endmodule // perf_event_counter_unit

// [verif/hub_model.sv]
// Global monitor hub model facing the counter unit.
// Assumes one unit on the same clock; freeze delay set by the bench.
`timescale 1ns/1ps
module hub_model #(
  parameter int PAIR_COUNT = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [PAIR_COUNT-1:0] i_wrap_msg,
  input wire logic [3:0] i_delay,
  input wire logic i_clear,
  output logic o_global_freeze,
  output logic o_unit_wrap_bit
);
  logic [3:0] wait_reg;
  // =====
  // Record wrap, freeze after delay, hold until cleared
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_unit_wrap_bit <= 1'b0;
      o_global_freeze <= 1'b0;
      wait_reg <= 4'h0;
    end else if (i_clear) begin
      o_unit_wrap_bit <= 1'b0;
      o_global_freeze <= 1'b0;
    end else if (|i_wrap_msg && !o_unit_wrap_bit) begin
      o_unit_wrap_bit <= 1'b1;
      wait_reg <= i_delay;
      o_global_freeze <= (i_delay == 4'h0);
    end else if (o_unit_wrap_bit && wait_reg != 4'h0) begin
      wait_reg <= wait_reg - 4'h1;
      o_global_freeze <= (wait_reg == 4'h1);
    end
  end
endmodule // hub_model

// [verif/test_perf_event_counter_unit.sv]
// Self-checking bench for the performance event counter unit.
// Assumes the hub model on the far side and one 100 MHz clock.
`timescale 1ns/1ps
module test_perf_event_counter_unit;
  localparam int N = 4;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] idx = 4'h0;
  logic [63:0] wdata = 64'h0;
  logic [63:0] rdata;
  logic rvalid, gfreeze, frozen, hub_bit;
  logic [N-1:0] wmsg;
  logic [N*8-1:0] codes, subs;
  logic [N*8-1:0] incr = '0;
  logic [3:0] hub_delay = 4'h0;
  logic hub_clear = 1'b0;
  int num_errors = 0;
  int comparisons = 0;
  int msgs0 = 0;
  int msgs1 = 0;
  logic [7:0] thr [N];
  logic [7:0] code [N];
  logic prev [N];
  logic [47:0] exp_ctr [N];
  logic inv, edg;
  logic [31:0] ctl;

  perf_event_counter_unit #(.PAIR_COUNT(N), .INCR_W(8)) dut (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_idx(idx), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_global_freeze(gfreeze), .o_wrap_msg(wmsg), .o_frozen(frozen),
    .o_event_code(codes), .o_subevent_mask(subs), .i_event_incr(incr));
  hub_model #(.PAIR_COUNT(N)) hub (.i_ref_clk(i_ref_clk),
    .i_reset(i_reset), .i_wrap_msg(wmsg), .i_delay(hub_delay),
    .i_clear(hub_clear), .o_global_freeze(gfreeze),
    .o_unit_wrap_bit(hub_bit));

  // =====
  // Clock, message counting, watchdog
  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    if (wmsg[0] === 1'b1) msgs0++;
    if (wmsg[1] === 1'b1) msgs1++;
  end
  initial begin
    #900000;
    num_errors++;
    give_verdict();
  end

  // =====
  // Tasks and expectation
  task automatic check64(input string name, input logic [63:0] e,
      input logic [63:0] got);
    comparisons++;
    if (got !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, e, got);
    end
  endtask
  task automatic tick();
    @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [63:0] d);
    wr = 1'b1;
    idx = a;
    wdata = d;
    tick();
    wr = 1'b0;
    tick();
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [63:0] e,
      input string name);
    rd = 1'b1;
    idx = a;
    tick();
    rd = 1'b0;
    check64("rvalid", 64'h1, 64'(rvalid));
    check64(name, e, rdata);
    tick();
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic logic [47:0] step(int g, logic [7:0] x);
    logic cur;
    cur = inv ? (x < thr[g]) : (x >= thr[g]);
    step = (thr[g] == 8'h0) ? 48'(x) : 48'(edg ? cur & ~prev[g] : cur);
    if (code[g] == 8'h0) step = 48'h0;
    prev[g] = cur;
  endfunction

  // =====
  // Main sequence
  initial begin
    void'($urandom(10586));
    repeat (8) @(posedge i_ref_clk);
    #1 i_reset = 1'b0;
    check64("frozen", 64'h0, 64'(frozen));
    rd_chk(4'h1, 64'h0, "status");
    rd_chk(4'h2, 64'h0, "ctl");
    rd_chk(4'h8, 64'h0, "ctr");
    wr_reg(4'h0, 64'h1);
    check64("frozen", 64'h1, 64'(frozen));
    for (int m = 0; m < 5; m++) begin
      inv = (m == 2 || m == 4);
      edg = (m >= 3);
      for (int g = 0; g < N; g++) begin
        thr[g] = (m == 0) ? 8'h0 : 8'($urandom_range(255, 1));
        code[g] = (m == 0 && g == N-1) ? 8'h0 : 8'($urandom_range(255, 1));
        ctl = {thr[g], inv, 4'h0, edg, 2'h0, 8'($urandom), code[g]};
        wr_reg(4'h2 + 4'(g), {32'h0, ctl});
        rd_chk(4'h2 + 4'(g), {32'h0, ctl}, "ctl");
        check64("code", 64'(code[g]), 64'(codes[g*8+:8]));
        check64("subevent", 64'(ctl[15:8]), 64'(subs[g*8+:8]));
        exp_ctr[g] = 48'h0;
        prev[g] = inv;
      end
      repeat (2) tick();
      wr_reg(4'h0, 64'h200);
      for (int g = 0; g < N; g++) exp_ctr[g] += step(g, 8'h0);
      for (int c = 0; c < 40; c++) begin
        for (int g = 0; g < N; g++) begin
          incr[g*8+:8] = (c % 4 == 0) ? thr[g] :
            (c % 4 == 1) ? thr[g] - 8'h1 : 8'($urandom);
          exp_ctr[g] += step(g, incr[g*8+:8]);
        end
        wr = (c == 39);
        wdata = 64'h1;
        idx = 4'h0;
        tick();
      end
      wr = 1'b0;
      repeat (5) begin
        incr = 32'($urandom);
        tick();
      end
      incr = '0;
      for (int g = 0; g < N; g++)
        rd_chk(4'h8 + 4'(g), {16'h0, exp_ctr[g]}, "ctr");
    end
    wr_reg(4'h0, 64'h101);
    rd_chk(4'h2, 64'h0, "ctl");
    check64("code", 64'h0, 64'(codes));
    wr_reg(4'h2, 64'h100001);
    wr_reg(4'h3, 64'h1);
    wr_reg(4'h8, 64'hFFFF_FFFF_FFFD);
    wr_reg(4'h9, '1);
    rd_chk(4'h9, 64'h0000_FFFF_FFFF_FFFF, "ctr");
    incr = 32'h0101;
    hub_delay = 4'h1;
    wr_reg(4'h0, 64'h0);
    exp_ctr[0] = 48'hFFFF_FFFF_FFFE;
    exp_ctr[1] = 48'h0;
    repeat (12) begin
      if (!gfreeze) begin
        exp_ctr[0] += 48'h1;
        exp_ctr[1] += 48'h1;
      end
      tick();
    end
    incr = '0;
    rd_chk(4'h8, {16'h0, exp_ctr[0]}, "ctr");
    rd_chk(4'h9, {16'h0, exp_ctr[1]}, "ctr");
    rd_chk(4'h1, 64'h3, "status");
    check64("msgs0", 64'h1, 64'(msgs0));
    check64("msgs1", 64'h0, 64'(msgs1));
    check64("hub_bit", 64'h1, 64'(hub_bit));
    hub_clear = 1'b1;
    tick();
    hub_clear = 1'b0;
    hub_delay = 4'h5;
    wr_reg(4'h8, 64'hFFFF_FFFF_FFFE);
    incr = 32'h1;
    repeat (12) tick();
    check64("msgs0", 64'h1, 64'(msgs0));
    check64("gfreeze", 64'h0, 64'(gfreeze));
    incr = '0;
    wr_reg(4'h1, 64'h0);
    rd_chk(4'h1, 64'h3, "status");
    wr_reg(4'h1, 64'h1);
    rd_chk(4'h1, 64'h2, "status");
    wr_reg(4'h8, 64'hFFFF_FFFF_FFFE);
    incr = 32'h1;
    repeat (12) tick();
    check64("msgs0", 64'h2, 64'(msgs0));
    check64("gfreeze", 64'h1, 64'(gfreeze));
    incr = '0;
    wr_reg(4'h2, 64'h120001);
    rd_chk(4'h8, 64'h0, "ctr");
    rd_chk(4'h2, 64'h100001, "ctl");
    wr_reg(4'h7, 64'($urandom));
    rd_chk(4'h7, 64'h0, "unmapped");
    rd_chk(4'hF, 64'h0, "unmapped");
    rd_chk(4'h0, 64'h0, "unit_ctl");
    give_verdict();
  end
endmodule // test_perf_event_counter_unit
